// ### verilog/dtcp_port.sv
// Digital control pins: trigger in, trigger out and output-couple lines
//
// Summary of operation
// R1: Any pin may serve as trigger input
// R2: Polarity picks rising or falling trigger edge
// R3: Source holds trigger pulse at least 2 us
// R4: Edge becomes trigger well under 450 us
// R5: Triggers used only when pin source selected
// R6: Any trigger input pin fires, ORed together
// R7: Any pin may emit 10 us trigger pulse
// R8: Output pulse direction follows pin polarity
// R9: Pulse at list step begin and end
// R10: Couple roles allowed on first three pins
// R11: At most one couple-on, one couple-off pin
// R12: Couple pins fixed to negative polarity
// R13: Couple pins both drive and sense falls
// R14: Couple request switches all coupled outputs
// R15: All-outputs key switches coupled and uncoupled
// R16: Linked units need coupling on and output
// R17: Delay offsets equal the group's longest
// R18: Synchronise and deglitch inputs before edges
// R19: Couple pins drive low only, open drain
`timescale 1ns/10ps
`default_nettype none
`include "dtcp_map.svh"

module dtcp_port
  import dtcp_pkg::*;
#(
  parameter int NPINS = 4,
  parameter int FILT_CYC = `DTCP_MIN_PULSE_CYC,
  parameter int PULSE_CYC = `DTCP_OUT_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire dtcp_pin_cfg_t [NPINS-1:0] pin_cfg,
  input wire logic logger_pin_trigger_source,
  input wire logic list_pin_trigger_source,
  input wire logic trigger_event,
  input wire logic step_begin_trigger_flag,
  input wire logic step_end_trigger_flag,
  input wire logic list_step_begin,
  input wire logic list_step_end,
  input wire logic coupling_enable,
  input wire dtcp_out_req_t out_req,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic logger_trigger,
  output logic list_trigger,
  output logic couple_on_cmd,
  output logic couple_off_cmd,
  output logic all_on_cmd,
  output logic all_off_cmd,
  output logic [NPINS-1:0] cfg_reject
);
  localparam int FW = $clog2(FILT_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);

  // ==========================================================
  // Pin configuration checks
  // ==========================================================
  logic [NPINS-1:0] is_tin, is_trigger_output_function, want_on, want_off, ok_on, ok_off, eff_neg;
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_cfg
      // Couple roles only on low pins, first pin of each role wins
      assign want_on[g] = (pin_cfg[g].func == DTCP_COUPLE_ON);
      assign want_off[g] = (pin_cfg[g].func == DTCP_COUPLE_OFF);
      if (g == 0) begin : g_first
        assign ok_on[g] = want_on[g]; // see R10
        assign ok_off[g] = want_off[g];
      end else begin : g_rest
        assign ok_on[g] = want_on[g] && (g < `DTCP_COUPLE_PINS)
                          && !(|want_on[g-1:0]); // see R11
        assign ok_off[g] = want_off[g] && (g < `DTCP_COUPLE_PINS)
                           && !(|want_off[g-1:0]); // see R11
      end
      assign cfg_reject[g] = (want_on[g] && !ok_on[g]) || (want_off[g] && !ok_off[g]);
      assign is_tin[g] = (pin_cfg[g].func == DTCP_TRIG_IN); // see R1
      assign is_trigger_output_function[g] = (pin_cfg[g].func == DTCP_TRIG_OUT); // see R7
      // Couple pins ignore programmed polarity
      assign eff_neg[g] = (ok_on[g] || ok_off[g]) ? 1'b1 : pin_cfg[g].pol_neg; // see R12
    end
  endgenerate

  // ==========================================================
  // Input synchroniser and glitch filter
  // ==========================================================
  logic [NPINS-1:0] sync1_ff, sync2_ff, filt_ff, filt_d_ff;
  logic [NPINS-1:0][FW-1:0] fcnt_ff;
  // Two-flop synchroniser, reset to the idle high level so no false edge follows reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
    end else begin
      sync1_ff <= pin_in; // see R18
      sync2_ff <= sync1_ff;
    end
  end

  generate
    for (g = 0; g < NPINS; g++) begin : g_filt
      // Level accepted only after it stays stable for the filter time
      always_ff @(posedge core_clk) begin
        if (srst) begin
          filt_ff[g] <= 1'b1;
          filt_d_ff[g] <= 1'b1;
          fcnt_ff[g] <= '0;
        end else begin
          filt_d_ff[g] <= filt_ff[g];
          if (sync2_ff[g] == filt_ff[g]) begin
            fcnt_ff[g] <= '0;
          end else if (fcnt_ff[g] == FW'(FILT_CYC - 1)) begin
            filt_ff[g] <= sync2_ff[g]; // see R18
            fcnt_ff[g] <= '0;
          end else begin
            fcnt_ff[g] <= fcnt_ff[g] + FW'(1);
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Edge detection and trigger combining
  // ==========================================================
  wire [NPINS-1:0] rise = filt_ff & ~filt_d_ff;
  wire [NPINS-1:0] fall = ~filt_ff & filt_d_ff;
  // Active edge per polarity
  wire [NPINS-1:0] act_edge = (eff_neg & fall) | (~eff_neg & rise); // see R2
  wire any_tin = |(act_edge & is_tin); // see R6
  wire on_sense = |(fall & ok_on); // see R13
  wire off_sense = |(fall & ok_off);

  // Triggers gated by source selection, registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      logger_trigger <= 1'b0;
      list_trigger <= 1'b0;
    end else begin
      logger_trigger <= any_tin && logger_pin_trigger_source; // see R5
      list_trigger <= any_tin && list_pin_trigger_source; // see R4
    end
  end

  // ==========================================================
  // Trigger output pulse
  // ==========================================================
  wire trigger_output_function_fire = trigger_event || (step_begin_trigger_flag && list_step_begin)
                   || (step_end_trigger_flag && list_step_end); // see R9
  dtcp_pulse_st_t pst_ff;
  logic [PW-1:0] pcnt_ff;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pst_ff <= DTCP_P_IDLE;
      pcnt_ff <= '0;
    end else begin
      case (pst_ff)
        DTCP_P_IDLE: begin
          if (trigger_output_function_fire) begin
            pst_ff <= DTCP_P_HIGH; // see R7
            pcnt_ff <= '0;
          end
        end
        DTCP_P_HIGH: begin
          if (pcnt_ff == PW'(PULSE_CYC - 1)) begin
            pst_ff <= DTCP_P_IDLE;
          end else begin
            pcnt_ff <= pcnt_ff + PW'(1);
          end
        end
        default: pst_ff <= DTCP_P_IDLE;
      endcase
    end
  end
  wire pulse_act = (pst_ff == DTCP_P_HIGH);

  // ==========================================================
  // Couple requests and open-drain drive
  // ==========================================================
  logic on_drive_ff, off_drive_ff;
  logic [PW-1:0] ccnt_on_ff, ccnt_off_ff;
  wire cpl = coupling_enable;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      on_drive_ff <= 1'b0;
      off_drive_ff <= 1'b0;
      ccnt_on_ff <= '0;
      ccnt_off_ff <= '0;
    end else begin
      // Local request pulls the shared line low for one pulse time
      if (cpl && out_req.on_req && !on_drive_ff) begin
        on_drive_ff <= 1'b1; // see R13
        ccnt_on_ff <= '0;
      end else if (on_drive_ff) begin
        ccnt_on_ff <= ccnt_on_ff + PW'(1);
        if (ccnt_on_ff == PW'(PULSE_CYC - 1)) on_drive_ff <= 1'b0;
      end
      if (cpl && out_req.off_req && !off_drive_ff) begin
        off_drive_ff <= 1'b1;
        ccnt_off_ff <= '0;
      end else if (off_drive_ff) begin
        ccnt_off_ff <= ccnt_off_ff + PW'(1);
        if (ccnt_off_ff == PW'(PULSE_CYC - 1)) off_drive_ff <= 1'b0;
      end
    end
  end

  // Commands to the output sequencer, registered; request-driven ones last as long as the request, sensed falls give one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      couple_on_cmd <= 1'b0;
      couple_off_cmd <= 1'b0;
      all_on_cmd <= 1'b0;
      all_off_cmd <= 1'b0;
    end else begin
      couple_on_cmd <= cpl && (on_sense || (out_req.on_req && !(|ok_on))); // see R14
      couple_off_cmd <= cpl && (off_sense || (out_req.off_req && !(|ok_off)));
      all_on_cmd <= out_req.all_on_req; // see R15
      all_off_cmd <= out_req.all_off_req;
    end
  end

  // Pin drivers: couple lines pull low only, trigger out drives both levels
  generate
    for (g = 0; g < NPINS; g++) begin : g_drv
      wire cdrv = (ok_on[g] && on_drive_ff) || (ok_off[g] && off_drive_ff);
      assign pin_out[g] = is_trigger_output_function[g] ? (pulse_act ^ eff_neg[g]) : 1'b0; // see R8
      assign pin_oe[g] = is_trigger_output_function[g] || cdrv; // see R19
    end
  endgenerate
endmodule
`default_nettype wire

// ### verilog/dtcp_map.svh
// Offsets-free constants: pin functions, timing figures and derived cycle counts
`ifndef DTCP_MAP_SVH
`define DTCP_MAP_SVH
`define DTCP_CLK_MHZ 100
`define DTCP_MIN_PULSE_NS 2000
`define DTCP_MIN_PULSE_CYC ((`DTCP_MIN_PULSE_NS * `DTCP_CLK_MHZ + 999) / 1000)
`define DTCP_LATENCY_NS 450000
`define DTCP_LATENCY_CYC ((`DTCP_LATENCY_NS * `DTCP_CLK_MHZ) / 1000)
`define DTCP_OUT_PULSE_NS 10000
`define DTCP_OUT_PULSE_CYC ((`DTCP_OUT_PULSE_NS * `DTCP_CLK_MHZ + 999) / 1000)
`define DTCP_FUNC_OTHER 3'h0
`define DTCP_FUNC_TRIG_IN 3'h1
`define DTCP_FUNC_TRIG_OUT 3'h2
`define DTCP_FUNC_COUPLE_ON 3'h3
`define DTCP_FUNC_COUPLE_OFF 3'h4
`define DTCP_COUPLE_PINS 3
`endif

// ### verilog/dtcp_pkg.sv
// Types shared by the digital trigger and couple port
package dtcp_pkg;
  typedef enum logic [2:0] {
    DTCP_OTHER = 3'h0,
    DTCP_TRIG_IN = 3'h1,
    DTCP_TRIG_OUT = 3'h2,
    DTCP_COUPLE_ON = 3'h3,
    DTCP_COUPLE_OFF = 3'h4
  } dtcp_func_t;
  typedef struct packed {
    dtcp_func_t func;
    logic pol_neg;
  } dtcp_pin_cfg_t;
  typedef struct packed {
    logic on_req;
    logic off_req;
    logic all_on_req;
    logic all_off_req;
  } dtcp_out_req_t;
  typedef enum logic [1:0] {
    DTCP_P_IDLE = 2'b00,
    DTCP_P_HIGH = 2'b01
  } dtcp_pulse_st_t;
endpackage

// ### tb/dtcp_ext_model.sv
// Far-side model: trigger sources and chained supplies on the pin lines
`timescale 1ns/10ps
`default_nettype none
module dtcp_ext_model #(
  parameter int NPINS = 4
) (
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] ext_lvl,
  output logic [NPINS-1:0] pin_in
);
  // Pulled-up lines: remote level ANDed with our driver, wired-AND
  // Remote units share one delay offset, so one remote fall stands for the group
  assign pin_in = ext_lvl & (pin_out | ~pin_oe);
endmodule
`default_nettype wire

// ### tb/dtcp_port_props.sv
// Concurrent checks on the trigger and couple port
`timescale 1ns/10ps
`default_nettype none
module dtcp_port_props
  import dtcp_pkg::*;
#(
  parameter int NPINS = 4,
  parameter int PULSE_CYC = 1000
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire dtcp_pin_cfg_t [NPINS-1:0] pin_cfg,
  input wire logic logger_pin_trigger_source,
  input wire logic trigger_event,
  input wire logic coupling_enable,
  input wire dtcp_out_req_t out_req,
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic logger_trigger,
  input wire logic couple_on_cmd,
  input wire logic all_on_cmd,
  input wire logic all_off_cmd
);
  logic [NPINS-1:0] cpl;
  logic act;
  logic act_ff;
  logic [15:0] cnt_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Couple-role pins, and pin 0 away from its idle level
  always_comb begin
    for (int i = 0; i < NPINS; i++)
      cpl[i] = pin_cfg[i].func inside {DTCP_COUPLE_ON, DTCP_COUPLE_OFF};
  end
  assign act = pin_oe[0] && (pin_cfg[0].func == DTCP_TRIG_OUT) && (pin_out[0] ^ pin_cfg[0].pol_neg);
  // Length of the running output pulse
  always_ff @(posedge core_clk) begin
    act_ff <= act & ~srst;
    cnt_ff <= (srst || !act) ? 16'h0000 : cnt_ff + 16'h0001;
  end
  all_on_cmd_a: assert property (out_req.all_on_req |=> all_on_cmd)
    else $error("all-on command missing");
  all_off_cmd_a: assert property (out_req.all_off_req |=> all_off_cmd)
    else $error("all-off command missing");
  logger_gate_a: assert property (logger_trigger |-> $past(logger_pin_trigger_source))
    else $error("trigger without pin source");
  trig_single_a: assert property (logger_trigger |=> !logger_trigger)
    else $error("trigger longer than one cycle");
  pulse_start_a: assert property (trigger_event && !act && pin_cfg[0].func == DTCP_TRIG_OUT
    |=> act)
    else $error("output pulse did not start");
  pulse_width_a: assert property (act_ff && !act |-> cnt_ff == PULSE_CYC)
    else $error("output pulse width wrong");
  couple_low_a: assert property ((pin_oe & cpl) != 0 |-> (pin_oe & cpl & pin_out) == 0)
    else $error("couple line driven high");
  couple_gate_a: assert property (couple_on_cmd |-> $past(coupling_enable))
    else $error("couple command while coupling off");
endmodule
bind dtcp_port dtcp_port_props #(.NPINS(NPINS), .PULSE_CYC(PULSE_CYC)) u_props (
  .core_clk(core_clk), .srst(srst), .pin_cfg(pin_cfg), .trigger_event(trigger_event),
  .logger_pin_trigger_source(logger_pin_trigger_source), .coupling_enable(coupling_enable),
  .out_req(out_req), .pin_out(pin_out), .pin_oe(pin_oe), .logger_trigger(logger_trigger),
  .couple_on_cmd(couple_on_cmd), .all_on_cmd(all_on_cmd), .all_off_cmd(all_off_cmd)
);
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the trigger and couple port
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dtcp_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic log_src = 1'b1;
  logic lst_src = 1'b0;
  logic trig_ev = 1'b0;
  logic sb_flag = 1'b0;
  logic se_flag = 1'b0;
  logic step_b = 1'b0;
  logic step_e = 1'b0;
  logic cpl_en = 1'b0;
  dtcp_out_req_t out_req = '0;
  dtcp_pin_cfg_t [3:0] pin_cfg;
  logic [3:0] ext_lvl = 4'hF;
  logic [3:0] pin_in, pin_out, pin_oe, cfg_reject;
  logic lg_t, ls_t, c_on, c_off, a_on, a_off;
  logic [7:0] expq[$];
  int n_fail = 0;
  int samples_checked = 0;
  int p;
  wire logic [7:0] seen = {2'h0, c_off, c_on, a_off, a_on, ls_t, lg_t};
  dtcp_port #(.NPINS(4), .FILT_CYC(4), .PULSE_CYC(8)) uut (
    .core_clk(core_clk), .srst(srst), .pin_cfg(pin_cfg), .logger_pin_trigger_source(log_src),
    .list_pin_trigger_source(lst_src), .trigger_event(trig_ev), .step_begin_trigger_flag(sb_flag),
    .step_end_trigger_flag(se_flag), .list_step_begin(step_b), .list_step_end(step_e),
    .coupling_enable(cpl_en), .out_req(out_req), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .logger_trigger(lg_t), .list_trigger(ls_t), .couple_on_cmd(c_on),
    .couple_off_cmd(c_off), .all_on_cmd(a_on), .all_off_cmd(a_off), .cfg_reject(cfg_reject)
  );
  dtcp_ext_model #(.NPINS(4)) u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_in(pin_in));
  always #5 core_clk = ~core_clk;
  // ==========
  // Helpers
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic req(input dtcp_out_req_t r, input logic [7:0] e);
    if (e != 8'h00) expq.push_back(e);
    out_req = r;
    tick(1);
    out_req = '0;
    tick(14);
  endtask
  // Low pulse of w cycles from the far side
  task automatic ext_pulse(input int q, input int w, input logic [7:0] e);
    if (e != 8'h00) expq.push_back(e);
    ext_lvl[q] = 1'b0;
    tick(w);
    ext_lvl[q] = 1'b1;
    tick(20);
  endtask
  // Result watcher takes the oldest note for each result seen
  always @(negedge core_clk) begin
    if (!srst && seen !== 8'h00) begin
      if (expq.size() == 0) check(seen, 8'h00);
      else check(seen, expq.pop_front());
    end
  end
  initial begin
    #60000;
    n_fail++;
    print_verdict();
  end
  // ==========
  // Main sequence
  initial begin
    pin_cfg = {{DTCP_OTHER, 1'b1}, {DTCP_TRIG_IN, 1'b1}, {DTCP_TRIG_IN, 1'b0}, {DTCP_TRIG_OUT, 1'b0}};
    void'($urandom(32'h5491));
    tick(3);
    srst = 1'b0;
    req('{1'b0, 1'b0, 1'b1, 1'b0}, 8'h04);
    req('{1'b0, 1'b0, 1'b0, 1'b1}, 8'h08);
    for (int i = 0; i < 6; i++) begin
      p = 1 + int'($urandom_range(1, 0));
      ext_pulse(p, 6 + int'($urandom_range(4, 0)), 8'h01);
    end
    ext_pulse(1, 2, 8'h00);
    log_src = 1'b0;
    lst_src = 1'b1;
    ext_pulse(2, 8, 8'h02);
    lst_src = 1'b0;
    ext_pulse(1, 8, 8'h00);
    cpl_en = 1'b1;
    req('{1'b1, 1'b0, 1'b0, 1'b0}, 8'h10);
    cpl_en = 1'b0;
    trig_ev = 1'b1;
    tick(1);
    trig_ev = 1'b0;
    check({7'h0, pin_out[0]}, 8'h01);
    tick(12);
    pin_cfg[0].pol_neg = 1'b1;
    se_flag = 1'b1;
    tick(2);
    step_e = 1'b1;
    tick(1);
    step_e = 1'b0;
    check({7'h0, pin_out[0]}, 8'h00);
    tick(12);
    step_b = 1'b1;
    tick(1);
    step_b = 1'b0;
    check({7'h0, pin_out[0]}, 8'h01);
    sb_flag = 1'b1;
    step_b = 1'b1;
    tick(1);
    step_b = 1'b0;
    check({7'h0, pin_out[0]}, 8'h00);
    tick(12);
    pin_cfg[0] = '{DTCP_COUPLE_ON, 1'b1};
    pin_cfg[1] = '{DTCP_COUPLE_OFF, 1'b1};
    pin_cfg[3] = '{DTCP_COUPLE_ON, 1'b1};
    pin_cfg[2] = '{DTCP_COUPLE_ON, 1'b0};
    cpl_en = 1'b1;
    tick(12);
    check({4'h0, cfg_reject}, 8'h0C);
    expq.push_back(8'h10);
    out_req.on_req = 1'b1;
    tick(1);
    out_req.on_req = 1'b0;
    check({pin_oe, pin_out}, 8'h10);
    tick(14);
    ext_pulse(1, 8, 8'h20);
    req('{1'b0, 1'b1, 1'b0, 1'b0}, 8'h20);
    cpl_en = 1'b0;
    req('{1'b1, 1'b0, 1'b0, 1'b0}, 8'h00);
    check(8'(expq.size()), 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
